// file: verification/rtw_host_model.sv
// Host model driving the byte register port of the timer unit.
// Assumes one core clock; requests start just after a rising edge.
`timescale 1ns/100ps

module rtw_host_model
(
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle port at time zero
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One byte write; lines inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == rtw_pkg::ADDR_CTRL && d[5:4] == 2'h2 && d[1:0] == 2'h0)
      d[0] = 1'b1;  // No fastest tick with watchdog
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // One byte read; data taken once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    // Registered answer stands from the request edge on
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : rtw_host_model

// file: verification/rtw_timer_assertions.sv
// Checker for the timer unit's register port and interrupt output.
// Assumes it is bound onto rtw_timer and sees only its ports.
`timescale 1ns/100ps

module rtw_timer_chk
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Status
  input wire logic       second_interrupt_enable,
  input wire logic       timer_status_clear,
  input wire logic       timer_status_flag,
  input wire logic       second_interrupt_out_n
);
  // ==========================================================
  // Shadow of the run and repeat bits
  logic run_sh, rep_sh, next_run, next_rep, ctl_wr;
  always_comb
  begin
    ctl_wr   = reg_wr && reg_addr == rtw_pkg::ADDR_CTRL;
    next_run = ctl_wr ? reg_wdata[6] : run_sh;
    next_rep = rep_sh;
    if (ctl_wr && !(run_sh && reg_wdata[7]))  // Set refused if running
      next_rep = reg_wdata[7];
  end
  always_ff @(posedge core_clk)
  begin
    run_sh <= rst_n && next_run;
    rep_sh <= rst_n && next_rep;
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_lim_wr;
    reg_wr && reg_addr == rtw_pkg::ADDR_LIMIT;
  endsequence
  sequence s_lim_rd;
    reg_rd && reg_addr == rtw_pkg::ADDR_LIMIT && !reg_wr;
  endsequence
  a_limit_read_back: assert property (s_lim_wr ##1 !reg_wr ##1 s_lim_rd
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("limit lost");
  a_sub_reads_zero: assert property (reg_rd && reg_addr ==
    rtw_pkg::ADDR_SUB_LIMIT |=> reg_rdata == 8'h00)
    else $error("sub limit readable");
  a_ctrl_zero_bits: assert property (reg_rd && reg_addr ==
    rtw_pkg::ADDR_CTRL |=> reg_rdata[3:2] == 2'h0)
    else $error("ctrl bits 3:2 set");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_irq_enabled: assert property ($fell(second_interrupt_out_n)
    |-> $past(second_interrupt_enable)) else $error("irq ungated");
  a_irq_with_flag: assert property ($fell(second_interrupt_out_n)
    |-> timer_status_flag) else $error("irq without flag");
  a_flag_sticky: assert property (timer_status_flag && !timer_status_clear
    |=> timer_status_flag) else $error("flag dropped");
  a_level_hold: assert property (!second_interrupt_out_n && !rep_sh &&
    run_sh && second_interrupt_enable && !timer_status_clear && !ctl_wr
    |=> !second_interrupt_out_n) else $error("level irq lost");
endmodule : rtw_timer_chk

bind rtw_timer rtw_timer_chk u_chk
(
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .second_interrupt_enable(second_interrupt_enable),
  .timer_status_clear(timer_status_clear),
  .timer_status_flag(timer_status_flag),
  .second_interrupt_out_n(second_interrupt_out_n)
);

// file: verification/tb.sv
// Self-checking bench for the timer unit, host model on the port.
// Assumes a 50 MHz clock and the fastest tick of 12207 cycles.
`timescale 1ns/100ps

module tb;
  // ==========================================================
  // Signals and bench model
  logic        core_clk, rst_n, reg_wr, reg_rd, alarm, bat, crun;
  logic        irq_en, st_clr, flag, irq_n;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
  logic [31:0] seed;
  int          error_cnt, samples_checked, m_lim, n;
  logic [7:0]  amap [5] = '{8'h09, 8'h12, 8'h13, 8'h14, 8'h15};

  rtw_timer u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .alarm_status_flag(alarm), .on_battery(bat),
    .clock_running(crun), .second_interrupt_enable(irq_en),
    .timer_status_clear(st_clr), .timer_status_flag(flag),
    .second_interrupt_out_n(irq_n));
  rtw_host_model u_host (.core_clk(core_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  // Clock source
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Pseudo-random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    chk(v, e);
  endtask : rdc

  // Bounded wait for the status flag
  task automatic wait_flag(input int lim);
    n = 0;
    while (flag !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_flag

  task automatic pulse_clear;
    @(posedge core_clk);
    st_clr <= 1'b1;
    @(posedge core_clk);
    st_clr <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse_clear

  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Hang guard
  initial
  begin
    repeat (99000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_n, alarm, bat, st_clr} = 4'h0;
    {crun, irq_en} = 2'h3;
    seed = 32'hc9c0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (amap[i]) rdc(amap[i], 8'h00);
    repeat (4)
    begin
      seed = xs(seed);
      m_lim = seed[7:0];
      u_host.wr(rtw_pkg::ADDR_LIMIT, seed[7:0]);
      rdc(rtw_pkg::ADDR_LIMIT, 8'(m_lim));
      u_host.wr(rtw_pkg::ADDR_COUNT, seed[15:8]);
      u_host.wr(rtw_pkg::ADDR_SUB_LIMIT, seed[23:16]);
      rdc(rtw_pkg::ADDR_LIMIT, 8'(m_lim));
      rdc(rtw_pkg::ADDR_COUNT, 8'h00);
      rdc(rtw_pkg::ADDR_SUB_LIMIT, 8'h00);
    end
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'hbf);
    rdc(rtw_pkg::ADDR_CTRL, 8'hb3);
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'h00);
    // Count-down, sub limit 1: one tick per step
    u_host.wr(rtw_pkg::ADDR_LIMIT, 8'h02);  // Limit of two
    u_host.wr(rtw_pkg::ADDR_SUB_LIMIT, 8'h01);
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'h40);
    rdc(rtw_pkg::ADDR_COUNT, 8'h02);
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'hc0);
    rdc(rtw_pkg::ADDR_CTRL, 8'h40);
    wait_flag(24500);
    chk(8'(n > 12180 && n < 24500), 8'h01);
    chk(irq_n, 1'b0);
    rdc(rtw_pkg::ADDR_COUNT, 8'h00);
    pulse_clear();
    chk({flag, irq_n}, 2'h1);
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'h00);
    // Power-fail count-up in pulse mode
    u_host.wr(rtw_pkg::ADDR_SUB_LIMIT, 8'h01);
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'h80);
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'hf0);
    rdc(rtw_pkg::ADDR_COUNT, 8'h01);
    repeat (12400) @(posedge core_clk);
    rdc(rtw_pkg::ADDR_COUNT, 8'h01);
    bat <= 1'b1;
    wait_flag(12400);
    chk({flag, irq_n}, 2'h2);
    repeat (1000) @(posedge core_clk);
    chk(irq_n, 1'b0);
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({flag, irq_n}, 2'h3);
    rdc(rtw_pkg::ADDR_COUNT, 8'h00);
    pulse_clear();
    // Alarm-started count-down, interrupt masked
    irq_en <= 1'b0;
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'h50);
    repeat (12400) @(posedge core_clk);
    rdc(rtw_pkg::ADDR_COUNT, 8'h02);
    alarm <= 1'b1;
    repeat (12400) @(posedge core_clk);
    rdc(rtw_pkg::ADDR_COUNT, 8'h01);
    wait_flag(12400);
    chk({flag, irq_n}, 2'h3);
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'h00);
    // Watchdog start value
    u_host.wr(rtw_pkg::ADDR_CTRL, 8'h60);
    rdc(rtw_pkg::ADDR_COUNT, 8'h01);
    rdc(rtw_pkg::ADDR_CTRL, 8'h61);
    complete_run();
  end
endmodule : tb

// file: verilog/rtw_pkg.sv
// Package for the timer/watchdog unit of a real-time clock.
// Assumes a 50 MHz core clock and a byte-wide internal register port.
package rtw_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL      = 8'h09;
  localparam logic [7:0] ADDR_LIMIT     = 8'h12;
  localparam logic [7:0] ADDR_COUNT     = 8'h13;
  localparam logic [7:0] ADDR_SUB_LIMIT = 8'h14;

  // ==========================================================================
  // Control byte fields and reset values
  localparam int unsigned BIT_REPEAT = 7;
  localparam int unsigned BIT_RUN    = 6;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam logic [7:0]  ONE_BYTE   = 8'h01;
  localparam logic [6:0]  SUB_ONE    = 7'h01;
  localparam logic [6:0]  SUB_MAX    = 7'h7f;

  // Default sub-timer limits per tick select
  localparam logic [6:0] DEF_SUB_4K   = 7'h29;  // 41
  localparam logic [6:0] DEF_SUB_100  = 7'h64;  // 100
  localparam logic [6:0] DEF_SUB_SEC  = 7'h3c;  // 60
  localparam logic [6:0] DEF_SUB_MIN  = 7'h3c;  // 60

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK4K_HZ   = 4_096;
  localparam int unsigned TICK100_HZ  = 100;
  localparam int unsigned PULSE_MS    = 210;
  localparam int unsigned DIV_4K      = CLK_HZ / TICK4K_HZ;
  localparam int unsigned DIV_100     = CLK_HZ / TICK100_HZ;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned PULSE_CYC   = (CLK_HZ / 1000) * PULSE_MS;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    TICK_100HZ_4K, TICK_1S_100HZ, TICK_1M_1S, TICK_1H_1M
  } rtw_tick_e;

  typedef enum logic [1:0] {
    FN_COUNTDOWN, FN_ALARM_START, FN_WATCHDOG, FN_POWERFAIL
  } rtw_func_e;

  // Control byte layout
  typedef struct packed {
    logic      repeat_mode;
    logic      timer_run;
    rtw_func_e function_select;
    logic [1:0] zero_bits;
    rtw_tick_e tick_select;
  } rtw_ctrl_s;

endpackage : rtw_pkg

// file: verilog/rtw_timer.sv
// Timer/watchdog unit: sub-timer prescaler stepping a main counter,
// with a second interrupt output in level or pulse form.
// Assumes a synchronous byte register port driven by the serial engine.
//
// Function
// - Tick 00: 100Hz main, 4kHz sub, limit 41
// - Tick 01: 1s main, 100Hz sub, limit 100
// - Tick 10: 1s sub, limit 60, minute steps
// - Tick 11: 1min sub, limit 60, hour steps
// - Zero sub limit uses tick default
// - Sub limit at most 127
// - Sub wrap steps main counter by one
// - Function 00 plain count-down
// - Function 01 counts down after alarm flag
// - Function 10 count-up watchdog, periodic interrupts
// - Function 11 counts up on battery
// - Run bit gates timer, clears at reset
// - Interrupt output shown only when enabled
// - Repeat mode: 210ms low pulse per expiry
// - Level mode holds low until flag cleared or run bit cleared
// - Limit register read-write, resets zero
// - Count register read-only
// - Sub limit write-only, reads zero
// - Sub count hidden from host
// - Control byte layout, bits 3:2 zero
// - Enable loads limit or one, sub one
// - Expiry sets flag, asserts interrupt
`timescale 1ns/100ps

module rtw_timer
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Status and system inputs
  input  wire logic       alarm_status_flag,
  input  wire logic       on_battery,
  input  wire logic       clock_running,
  input  wire logic       second_interrupt_enable,
  input  wire logic       timer_status_clear,
  // Status and interrupt outputs
  output logic            timer_status_flag,
  output logic            second_interrupt_out_n
);

  // ==========================================================================
  // State
  rtw_pkg::rtw_ctrl_s ctrl, next_ctrl;          // Timer control byte
  logic [7:0]  timer_limit, next_timer_limit;   // Main limit
  logic [7:0]  timer_count_value, next_count;   // Main counter
  logic [6:0]  subtimer_limit, next_sub_limit;  // Written sub limit
  logic [6:0]  subtimer_count, next_sub_count;  // Hidden sub counter
  logic        status, next_status;             // Timer status flag
  logic        armed, next_armed;               // Counting cycle active
  logic        waiting, next_waiting;           // Expired in repeat mode, reload pending
  logic        irq_low, next_irq_low;           // Interrupt asserted
  logic [23:0] pulse_cnt, next_pulse_cnt;       // Pulse width counter
  logic [7:0]  rdata, next_rdata;               // Read data
  logic        run_q;                           // Run bit last cycle
  logic [19:0] div4k;                           // 4kHz divider
  logic [19:0] div100;                          // 100Hz divider
  logic [6:0]  sec_cnt, min_cnt;                // Second/minute prescalers
  logic        tick_4k, tick_100, tick_sec, tick_min;
  logic        expire;                          // Expiry in this cycle

  // ==========================================================================
  // Tick strobes from the timebase
  // Strobes are one cycle wide; second/minute stall while clock stopped
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      div4k    <= '0;
      div100   <= '0;
      sec_cnt  <= '0;
      min_cnt  <= '0;
      tick_4k  <= 1'b0;
      tick_100 <= 1'b0;
      tick_sec <= 1'b0;
      tick_min <= 1'b0;
    end
    else
    begin
      tick_4k  <= (div4k == 20'(rtw_pkg::DIV_4K - 1));
      tick_100 <= (div100 == 20'(rtw_pkg::DIV_100 - 1));
      tick_sec <= 1'b0;
      tick_min <= 1'b0;
      div4k  <= (div4k == 20'(rtw_pkg::DIV_4K - 1)) ? '0 : div4k + 20'h1;
      div100 <= (div100 == 20'(rtw_pkg::DIV_100 - 1)) ? '0 :
                div100 + 20'h1;
      if (tick_100 && clock_running)
      begin
        if (sec_cnt == 7'(rtw_pkg::TICK100_HZ - 1))
        begin
          sec_cnt  <= '0;
          tick_sec <= 1'b1;
          if (min_cnt == 7'(rtw_pkg::SEC_PER_MIN - 1))
          begin
            min_cnt  <= '0;
            tick_min <= 1'b1;
          end
          else
            min_cnt <= min_cnt + 7'h1;
        end
        else
          sec_cnt <= sec_cnt + 7'h1;
      end
    end
  end

  // ==========================================================================
  // Selected tick and effective sub-timer limit
  logic       sub_tick;
  logic [6:0] eff_sub_limit;
  logic       counts_up;
  logic       gate_open;
  always_comb
  begin
    unique case (ctrl.tick_select)
      rtw_pkg::TICK_100HZ_4K:
      begin
        sub_tick      = tick_4k;
        eff_sub_limit = rtw_pkg::DEF_SUB_4K;
      end
      rtw_pkg::TICK_1S_100HZ:
      begin
        sub_tick      = tick_100;
        eff_sub_limit = rtw_pkg::DEF_SUB_100;
      end
      rtw_pkg::TICK_1M_1S:
      begin
        sub_tick      = tick_sec;
        eff_sub_limit = rtw_pkg::DEF_SUB_SEC;
      end
      rtw_pkg::TICK_1H_1M:
      begin
        sub_tick      = tick_min;
        eff_sub_limit = rtw_pkg::DEF_SUB_MIN;
      end
    endcase
    if (subtimer_limit != '0)
      eff_sub_limit = subtimer_limit;
    counts_up = ctrl.function_select[1];
    unique case (ctrl.function_select)
      rtw_pkg::FN_COUNTDOWN:   gate_open = 1'b1;
      rtw_pkg::FN_ALARM_START: gate_open = alarm_status_flag;
      rtw_pkg::FN_WATCHDOG:    gate_open = 1'b1;
      rtw_pkg::FN_POWERFAIL:   gate_open = on_battery;
    endcase
  end

  // ==========================================================================
  // Register file and timer next state
  always_comb
  begin
    next_ctrl        = ctrl;
    next_timer_limit = timer_limit;
    next_sub_limit   = subtimer_limit;
    next_count       = timer_count_value;
    next_sub_count   = subtimer_count;
    next_status      = status;
    next_armed       = armed;
    next_waiting     = waiting;
    next_irq_low     = irq_low;
    next_pulse_cnt   = pulse_cnt;
    next_rdata       = rdata;
    expire           = 1'b0;
    // Host writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        rtw_pkg::ADDR_CTRL:
        begin
          next_ctrl           = rtw_pkg::rtw_ctrl_s'(reg_wdata);
          next_ctrl.zero_bits = 2'b00;
          // Repeat mode only changes while stopped or to turn it off
          if (ctrl.timer_run && reg_wdata[rtw_pkg::BIT_REPEAT])
            next_ctrl.repeat_mode = ctrl.repeat_mode;
        end
        rtw_pkg::ADDR_LIMIT: next_timer_limit = reg_wdata;
        rtw_pkg::ADDR_SUB_LIMIT:
          next_sub_limit = (reg_wdata[6:0] > rtw_pkg::SUB_MAX) ?
                           rtw_pkg::SUB_MAX : reg_wdata[6:0];
        default: ;                                   // Count is read-only
      endcase
    end
    // Host reads
    if (reg_rd)
    begin
      unique case (reg_addr)
        rtw_pkg::ADDR_CTRL:  next_rdata = 8'(ctrl);
        rtw_pkg::ADDR_LIMIT: next_rdata = timer_limit;
        rtw_pkg::ADDR_COUNT: next_rdata = timer_count_value;
        default:             next_rdata = rtw_pkg::ZERO_BYTE;
      endcase
    end
    // Enable edge loads counters
    if (ctrl.timer_run && !run_q)
    begin
      next_count     = counts_up ? rtw_pkg::ONE_BYTE : timer_limit;
      next_sub_count = rtw_pkg::SUB_ONE;
      next_armed     = 1'b1;
      next_waiting   = 1'b0;
    end
    else if (!ctrl.timer_run)
    begin
      // Stopped: counters at defaults, interrupt released
      next_count     = rtw_pkg::ZERO_BYTE;
      next_sub_count = rtw_pkg::SUB_ONE;
      next_armed     = 1'b0;
      next_waiting   = 1'b0;
      next_irq_low   = 1'b0;
    end
    else if (sub_tick && gate_open && (armed || ctrl.repeat_mode))
    begin
      if (subtimer_count >= eff_sub_limit)
      begin
        next_sub_count = rtw_pkg::SUB_ONE;
        if (waiting)
        begin
          // Periodic mode: restart count cycle at the first sub wrap after expiry
          next_waiting = 1'b0;
          next_count   = counts_up ? rtw_pkg::ONE_BYTE : timer_limit;
        end
        else
        begin
          next_count = counts_up ? timer_count_value + 8'h1 :
                       timer_count_value - 8'h1;
          if (counts_up ? (next_count == timer_limit) :
                          (next_count == rtw_pkg::ZERO_BYTE))
          begin
            expire         = 1'b1;
            next_status    = 1'b1;
            next_irq_low   = 1'b1;
            next_pulse_cnt = '0;
            next_waiting   = ctrl.repeat_mode;
            next_armed     = ctrl.repeat_mode;       // Single event stops
          end
        end
      end
      else
        next_sub_count = subtimer_count + 7'h1;
    end
    // Pulse mode: fixed low width
    if (ctrl.repeat_mode && irq_low && ctrl.timer_run)
    begin
      next_pulse_cnt = pulse_cnt + 24'h1;
      if (pulse_cnt == 24'(rtw_pkg::PULSE_CYC - 1))
        next_irq_low = 1'b0;
    end
    // Status clear: a new expiry in this cycle wins
    if (timer_status_clear && !expire)
    begin
      next_status = 1'b0;
      if (ctrl.timer_run)
      begin
        next_irq_low   = 1'b0;
        next_armed     = 1'b1;
        next_waiting   = 1'b0;
        next_count     = counts_up ? rtw_pkg::ONE_BYTE : timer_limit;
        next_sub_count = rtw_pkg::SUB_ONE;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl                   <= rtw_pkg::rtw_ctrl_s'(rtw_pkg::RST_BYTE);
      timer_limit            <= rtw_pkg::RST_BYTE;
      subtimer_limit         <= '0;
      timer_count_value      <= rtw_pkg::RST_BYTE;
      subtimer_count         <= rtw_pkg::SUB_ONE;
      status                 <= 1'b0;
      armed                  <= 1'b0;
      waiting                <= 1'b0;
      irq_low                <= 1'b0;
      pulse_cnt              <= '0;
      rdata                  <= rtw_pkg::ZERO_BYTE;
      run_q                  <= 1'b0;
      reg_rdata              <= rtw_pkg::ZERO_BYTE;
      timer_status_flag      <= 1'b0;
      second_interrupt_out_n <= 1'b1;
    end
    else
    begin
      ctrl                   <= next_ctrl;
      timer_limit            <= next_timer_limit;
      subtimer_limit         <= next_sub_limit;
      timer_count_value      <= next_count;
      subtimer_count         <= next_sub_count;
      status                 <= next_status;
      armed                  <= next_armed;
      waiting                <= next_waiting;
      irq_low                <= next_irq_low;
      pulse_cnt              <= next_pulse_cnt;
      rdata                  <= next_rdata;
      run_q                  <= ctrl.timer_run;
      reg_rdata              <= next_rdata;
      timer_status_flag      <= next_status;
      second_interrupt_out_n <= !(next_irq_low &&
                                  second_interrupt_enable);
    end
  end

endmodule : rtw_timer
